//--- bccs_condition_status.sv
// Controller condition status register, flag logic, run state and trap interrupt
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
module bccs_condition_status #(
    parameter int FLAGS   = bccs_pkg::FLAG_W,
    parameter int RESULTS = bccs_pkg::RESULT_W
) (
    input  wire logic                            sys_clk,
    input  wire logic                            rst,
    input  wire logic [bccs_pkg::ADDR_W-1:0]     addr,
    input  wire logic [bccs_pkg::DATA_W-1:0]     wrData,
    input  wire logic                            wrEn,
    input  wire logic                            rdEn,
    output logic [bccs_pkg::DATA_W-1:0]          rdData,
    input  wire logic                            controllerEnablePin,
    input  wire logic                            haltOp,
    input  wire logic                            illegalOpcode,
    input  wire logic                            flagManipulateOp,
    input  wire bccs_pkg::bccs_flag_mode_t       flagOpMode,
    input  wire logic [FLAGS-1:0]                flagOpMask,
    input  wire logic                            frameTimerCompareOp,
    input  wire logic                            messageTimerCompareOp,
    input  wire logic                            compareLess,
    input  wire logic                            compareEqual,
    input  wire logic                            messageDone,
    input  wire logic [RESULTS-1:0]              messageResult,
    output logic                                 controllerRunning,
    output logic                                 controllerTrapIrq
);
    import bccs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Parameter check

    if (FLAGS != FLAG_W || RESULTS != RESULT_W) begin : gBadParam
        $error("Flag and result widths must fill the 16-bit register");
    end

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    bccs_run_t                 runState;
    bccs_run_t                 next_runState;
    logic                      cfgEnable;
    logic [FLAGS-1:0]          flags;
    logic [FLAGS-1:0]          afterHost;
    logic [FLAGS-1:0]          next_flags;
    logic [RESULTS-1:0]        resultBits;
    logic [IRQ_W-1:0]          irqStatus;
    logic [IRQ_W-1:0]          irqMask;
    logic [IRQ_W-1:0]          irqEvents;
    logic [DATA_W-1:0]         condWord;
    logic [FLAGS-1:0]          hostMask;
    bccs_flag_mode_t           hostMode;
    logic                      cfgWrite;
    logic                      flagWrite;
    logic                      launchReq;
    logic                      stopCond;
    logic                      compareOp;

    ////////////////////////////////////////////////////////////////////////
    // Decode

    assign cfgWrite  = wrEn && (addr == ADDR_MASTER_CFG);
    // Shared address: a write lands in the flag register only
    assign flagWrite = wrEn && (addr == ADDR_COND_STATUS);
    assign hostMask  = wrData[FLAGS-1:0];
    assign hostMode  = bccs_flag_mode_t'(wrData[FLAG_MODE_LSB +: 2]);
    assign compareOp = frameTimerCompareOp || messageTimerCompareOp;

    // Launch sees the enable bit being written in the same cycle
    assign launchReq = cfgWrite && wrData[CFG_LAUNCH_POS]
                    && wrData[CFG_ENABLE_POS] && controllerEnablePin;
    assign stopCond  = !controllerEnablePin || !cfgEnable
                    || haltOp || illegalOpcode;

    ////////////////////////////////////////////////////////////////////////
    // Master configuration enable bit; launch bit is a pulse, not stored

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfgEnable <= CFG_ENABLE_RESET;
        end else if (cfgWrite) begin
            cfgEnable <= wrData[CFG_ENABLE_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Run / stop state

    always_comb begin
        next_runState = runState;
        case (runState)
            RUN_STOPPED: begin
                if (launchReq) begin
                    next_runState = RUN_ACTIVE;
                end
            end
            RUN_ACTIVE: begin
                // Any stop cause wins over a relaunch in the same cycle
                if (stopCond) begin
                    next_runState = RUN_STOPPED;
                end
            end
            default: next_runState = RUN_STOPPED;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            runState <= RUN_STOPPED;
        end else begin
            runState <= next_runState;
        end
    end

    assign controllerRunning = (runState == RUN_ACTIVE);

    ////////////////////////////////////////////////////////////////////////
    // General purpose flags: host first, then sequencer ops

    bccs_flag_unit #(
        .WIDTH    (FLAGS)
    ) uHostFlags (
        .flagsIn  (flags),
        .apply    (flagWrite),
        .mode     (hostMode),
        .mask     (hostMask),
        .flagsOut (afterHost)
    );

    bccs_flag_unit #(
        .WIDTH    (FLAGS)
    ) uSeqFlags (
        .flagsIn  (afterHost),
        .apply    (flagManipulateOp),
        .mode     (flagOpMode),
        .mask     (flagOpMask),
        .flagsOut (next_flags)
    );

    // The sequencer acted last, so its compare result overrides bits 1-0
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flags <= FLAGS_RESET;
        end else if (compareOp) begin
            flags <= {next_flags[FLAGS-1:2], compareLess, compareEqual};
        end else begin
            flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Message result bits

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resultBits <= RESULT_RESET;
        end else if (messageDone) begin
            resultBits <= messageResult;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    always_comb begin
        irqEvents = '0;
        irqEvents[IRQ_TRAP_POS] = controllerRunning && illegalOpcode;
        irqEvents[IRQ_HALT_POS] = controllerRunning && haltOp;
    end

    // A new event beats a write-one clear in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqStatus <= IRQ_RESET;
        end else begin
            irqStatus <= (irqStatus & ~((wrEn && addr == ADDR_IRQ_STATUS)
                          ? wrData[IRQ_W-1:0] : IRQ_RESET)) | irqEvents;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irqMask <= IRQ_RESET;
        end else if (wrEn && addr == ADDR_IRQ_MASK) begin
            irqMask <= wrData[IRQ_W-1:0];
        end
    end

    assign controllerTrapIrq = |(irqStatus & irqMask);

    ////////////////////////////////////////////////////////////////////////
    // Read port; reads only sample state

    assign condWord = {controllerRunning, resultBits, flags};

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rdData <= READ_IDLE;
        end else if (rdEn) begin
            case (addr)
                ADDR_COND_STATUS: rdData <= condWord;
                ADDR_MASTER_CFG:  rdData <= DATA_W'({cfgEnable, 12'h000});
                ADDR_IRQ_STATUS:  rdData <= DATA_W'(irqStatus);
                ADDR_IRQ_MASK:    rdData <= DATA_W'(irqMask);
                default:          rdData <= READ_IDLE;
            endcase
        end else begin
            rdData <= READ_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_WRITE_SKIPS_RESULT: assert property (
        flagWrite && !messageDone && !(controllerRunning && stopCond)
        |=> $stable(resultBits) && $stable(runState))
        else $error("Write to shared address touched read-only bits");

    AST_READ_RETURNS_WORD: assert property (
        rdEn && addr == ADDR_COND_STATUS |=> rdData == $past(condWord)
        && rdData[RUN_POS] == $past(controllerRunning))
        else $error("Condition read did not return the status word");

    AST_RESULT_CAPTURE: assert property (
        messageDone ##1 (!messageDone)[*2] |-> resultBits == $past(messageResult, 2))
        else $error("Message result not held");

    AST_HOST_SET: assert property (
        flagWrite && hostMode == FLAG_SET && !flagManipulateOp && !compareOp
        |=> flags == ($past(flags) | $past(hostMask)))
        else $error("Host set of flags wrong");

    AST_SEQ_TOGGLE: assert property (
        flagManipulateOp && flagOpMode == FLAG_TOGGLE && !flagWrite && !compareOp
        |=> flags == ($past(flags) ^ $past(flagOpMask)))
        else $error("Sequencer toggle of flags wrong");

    AST_COMPARE_BITS: assert property (
        compareOp |=> flags[1] == $past(compareLess) && flags[0] == $past(compareEqual))
        else $error("Compare result not in flag bits 1-0");

    AST_LAUNCH: assert property (
        !controllerRunning && launchReq |=> controllerRunning)
        else $error("Launch did not start the controller");

    AST_NO_LAUNCH_DISABLED: assert property (
        !controllerRunning && !(cfgWrite && wrData[CFG_ENABLE_POS] && controllerEnablePin)
        |=> !controllerRunning)
        else $error("Controller started without enables");

    AST_STOP: assert property (
        controllerRunning && (haltOp || !controllerEnablePin || !cfgEnable)
        |=> !controllerRunning)
        else $error("Controller did not stop");

    AST_TRAP: assert property (
        controllerRunning && illegalOpcode && irqMask[IRQ_TRAP_POS]
        && !(wrEn && addr == ADDR_IRQ_MASK)
        |=> !controllerRunning && controllerTrapIrq && irqStatus[IRQ_TRAP_POS])
        else $error("Illegal opcode did not trap");

    AST_RESET_STOPPED: assert property (disable iff (1'b0)
        rst |=> !controllerRunning && flags == FLAGS_RESET)
        else $error("Not stopped after reset");

    AST_READ_QUIET: assert property (
        rdEn && !wrEn && !flagManipulateOp && !compareOp && !messageDone
        && !controllerRunning && !launchReq
        |=> $stable(flags) && $stable(resultBits) && $stable(runState) && $stable(irqStatus))
        else $error("Read changed state");

    ////////////////////////////////////////////////////////////////////////
    // Further flag, run and port checks

    AST_HOST_CLEAR: assert property (
        flagWrite && hostMode == FLAG_CLEAR && !flagManipulateOp && !compareOp
        |=> flags == ($past(flags) & ~$past(hostMask)))
        else $error("Host clear of flags wrong");

    AST_HOST_TOGGLE: assert property (
        flagWrite && hostMode == FLAG_TOGGLE && !flagManipulateOp && !compareOp
        |=> flags == ($past(flags) ^ $past(hostMask)))
        else $error("Host toggle of flags wrong");

    AST_SEQ_SET: assert property (
        flagManipulateOp && flagOpMode == FLAG_SET && !flagWrite && !compareOp
        |=> flags == ($past(flags) | $past(flagOpMask)))
        else $error("Sequencer set of flags wrong");

    AST_SEQ_CLEAR: assert property (
        flagManipulateOp && flagOpMode == FLAG_CLEAR && !flagWrite && !compareOp
        |=> flags == ($past(flags) & ~$past(flagOpMask)))
        else $error("Sequencer clear of flags wrong");

    // Compare ops own bits 1-0 only; the rest must ride through untouched
    AST_COMPARE_KEEPS_HIGH: assert property (
        compareOp && !flagWrite && !flagManipulateOp
        |=> flags[FLAGS-1:2] == $past(flags[FLAGS-1:2]))
        else $error("Compare op disturbed flag bits above bit 1");

    AST_RESULT_HOLD: assert property (
        !messageDone |=> $stable(resultBits))
        else $error("Message result changed without a message");

    AST_CFG_ENABLE_STORED: assert property (
        cfgWrite |=> cfgEnable == $past(wrData[CFG_ENABLE_POS]))
        else $error("Enable bit not stored by a configuration write");

    AST_HALT_EVENT: assert property (
        controllerRunning && haltOp |=> !controllerRunning && irqStatus[IRQ_HALT_POS])
        else $error("Halt did not stop and flag the controller");

    AST_TRAP_UNMASKED: assert property (
        controllerRunning && illegalOpcode |=> !controllerRunning && irqStatus[IRQ_TRAP_POS])
        else $error("Illegal opcode did not stop and flag the controller");

    // Events only count while running, so a stopped block keeps its status
    AST_STOPPED_NO_EVENT: assert property (
        !controllerRunning && !(wrEn && addr == ADDR_IRQ_STATUS) |=> $stable(irqStatus))
        else $error("Interrupt status changed while stopped");

    // Status may stay set while masked; only the mask gates the pin
    AST_IRQ_MASKED: assert property (
        irqMask == IRQ_RESET |-> !controllerTrapIrq)
        else $error("Interrupt raised with every source masked");

    AST_READ_IDLE: assert property (
        !rdEn |=> rdData == READ_IDLE)
        else $error("Read data stood outside a read");

    COV_LAUNCH: cover property (launchReq ##1 controllerRunning);
    COV_HALT: cover property (controllerRunning && haltOp ##1 !controllerRunning);
    COV_TRAP: cover property (controllerRunning && illegalOpcode ##1 controllerTrapIrq);
    COV_TOGGLE: cover property (flagWrite && hostMode == FLAG_TOGGLE);
    COV_RESULT: cover property (messageDone ##1 resultBits != RESULT_RESET);

endmodule : bccs_condition_status

//--- bccs_condition_status_tb.sv
// Register-level testbench of the controller condition status block
`timescale 1ns/1ps
module bccs_condition_status_tb;
    import bccs_pkg::*;

    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [15:0] wrData = 16'h0000;
    logic        wrEn = 1'b0;
    logic        rdEn = 1'b0;
    logic        pin = 1'b0;
    logic [15:0] rdData;
    logic        haltOp, illegalOpcode, flagManipulateOp, frameTimerCompareOp;
    logic        messageTimerCompareOp, compareLess, compareEqual, messageDone;
    logic        controllerRunning, controllerTrapIrq;
    logic [7:0]  flagOpMask;
    logic [6:0]  messageResult;
    bccs_flag_mode_t flagOpMode;
    int          failures = 0;
    int          samplesChecked = 0;
    logic [15:0] fw [4] = '{16'h00a5, 16'h0105, 16'h02ff, 16'h033c};
    logic [15:0] fe [4] = '{16'h00a5, 16'h00a0, 16'h005f, 16'h003c};

    always #12.5 sys_clk = ~sys_clk;

    bccs_condition_status uut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wrData(wrData), .wrEn(wrEn),
        .rdEn(rdEn), .rdData(rdData), .controllerEnablePin(pin), .haltOp(haltOp),
        .illegalOpcode(illegalOpcode), .flagManipulateOp(flagManipulateOp), .flagOpMode(flagOpMode),
        .flagOpMask(flagOpMask), .frameTimerCompareOp(frameTimerCompareOp),
        .messageTimerCompareOp(messageTimerCompareOp), .compareLess(compareLess),
        .compareEqual(compareEqual), .messageDone(messageDone), .messageResult(messageResult),
        .controllerRunning(controllerRunning), .controllerTrapIrq(controllerTrapIrq));

    bccs_seq_model seq (.sys_clk(sys_clk), .haltOp(haltOp), .illegalOpcode(illegalOpcode),
        .flagManipulateOp(flagManipulateOp), .flagOpMode(flagOpMode), .flagOpMask(flagOpMask),
        .frameTimerCompareOp(frameTimerCompareOp), .messageTimerCompareOp(messageTimerCompareOp),
        .compareLess(compareLess), .compareEqual(compareEqual), .messageDone(messageDone),
        .messageResult(messageResult));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        wrEn <= 1'b1;
        addr <= a;
        wrData <= d;
        @(posedge sys_clk);
        wrEn <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe edge
    task automatic rdChk(input logic [15:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        rdEn <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rdEn <= 1'b0;
        #1;
        check(rdData, exp);
    endtask : rdChk

    task automatic waitCyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : waitCyc

    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rdChk(ADDR_COND_STATUS, 16'h0000);
        check({15'h0, controllerRunning}, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_COND_STATUS, fw[i]);
            rdChk(ADDR_COND_STATUS, fe[i]);
        end
        $display("test host flags done");
        seq.fire(3'h2, FLAG_SET, 8'h80);
        rdChk(ADDR_COND_STATUS, 16'h00bc);
        seq.fire(3'h2, FLAG_TOGGLE, 8'h0f);
        rdChk(ADDR_COND_STATUS, 16'h00b3);
        seq.fire(3'h2, FLAG_CLEAR, 8'h30);
        rdChk(ADDR_COND_STATUS, 16'h0083);
        seq.fire(3'h2, FLAG_LOAD, 8'h5a);
        rdChk(ADDR_COND_STATUS, 16'h005a);
        seq.fire(3'h3, FLAG_SET, 8'h01);
        rdChk(ADDR_COND_STATUS, 16'h0059);
        seq.fire(3'h4, FLAG_SET, 8'h02);
        rdChk(ADDR_COND_STATUS, 16'h005a);
        seq.fire(3'h4, FLAG_SET, 8'h03);
        seq.fire(3'h5, FLAG_SET, 8'h55);
        rdChk(ADDR_COND_STATUS, 16'h555b);
        rdChk(ADDR_COND_STATUS, 16'h555b);
        $display("test sequencer flags done");
        wr(ADDR_MASTER_CFG, 16'h3000);
        rdChk(ADDR_COND_STATUS, 16'h555b);
        pin <= 1'b1;
        wr(ADDR_MASTER_CFG, 16'h2000);
        rdChk(ADDR_COND_STATUS, 16'h555b);
        wr(ADDR_MASTER_CFG, 16'h3000);
        rdChk(ADDR_COND_STATUS, 16'hd55b);
        // Upper bits of the write data must not reach the status byte
        wr(ADDR_COND_STATUS, 16'hff00);
        rdChk(ADDR_COND_STATUS, 16'hd500);
        seq.fire(3'h0, FLAG_SET, 8'h00);
        rdChk(ADDR_COND_STATUS, 16'h5500);
        rdChk(ADDR_IRQ_STATUS, 16'h0002);
        wr(ADDR_IRQ_STATUS, 16'h0003);
        rdChk(ADDR_IRQ_STATUS, 16'h0000);
        wr(ADDR_MASTER_CFG, 16'h3000);
        pin <= 1'b0;
        waitCyc(2);
        rdChk(ADDR_COND_STATUS, 16'h5500);
        pin <= 1'b1;
        wr(ADDR_MASTER_CFG, 16'h3000);
        waitCyc(0);
        check({15'h0, controllerRunning}, 16'h0001);
        wr(ADDR_MASTER_CFG, 16'h0000);
        waitCyc(2);
        rdChk(ADDR_COND_STATUS, 16'h5500);
        $display("test run control done");
        wr(ADDR_IRQ_MASK, 16'h0001);
        wr(ADDR_MASTER_CFG, 16'h3000);
        seq.fire(3'h1, FLAG_SET, 8'h00);
        waitCyc(1);
        check({14'h0, controllerRunning, controllerTrapIrq}, 16'h0001);
        rdChk(ADDR_IRQ_STATUS, 16'h0001);
        wr(ADDR_IRQ_STATUS, 16'h0001);
        waitCyc(1);
        check({15'h0, controllerTrapIrq}, 16'h0000);
        wr(ADDR_IRQ_MASK, 16'h0000);
        wr(ADDR_MASTER_CFG, 16'h3000);
        seq.fire(3'h1, FLAG_SET, 8'h00);
        waitCyc(1);
        check({14'h0, controllerRunning, controllerTrapIrq}, 16'h0000);
        rdChk(ADDR_IRQ_STATUS, 16'h0001);
        rdChk(ADDR_IRQ_MASK, 16'h0000);
        rdChk(16'h0100, 16'h0000);
        $display("test trap done");
        rdChk(ADDR_MASTER_CFG, 16'h1000);
        wr(ADDR_IRQ_MASK, 16'h0002);
        wr(ADDR_MASTER_CFG, 16'h3000);
        seq.fire(3'h0, FLAG_SET, 8'h00);
        waitCyc(1);
        check({14'h0, controllerRunning, controllerTrapIrq}, 16'h0001);
        // Reset in mid-run must stop the controller and clear every field
        wr(ADDR_MASTER_CFG, 16'h3000);
        rst <= 1'b1;
        waitCyc(2);
        check({14'h0, controllerRunning, controllerTrapIrq}, 16'h0000);
        rst <= 1'b0;
        rdChk(ADDR_COND_STATUS, 16'h0000);
        rdChk(ADDR_MASTER_CFG, 16'h0000);
        $display("test reset in run done");
        test_done();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge sys_clk);
        failures++;
        test_done();
    end
endmodule : bccs_condition_status_tb

//--- bccs_flag_unit.sv
// One set, clear, toggle or load step applied to a flag byte
`timescale 1ns/1ps
module bccs_flag_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0]             flagsIn,
    input  wire logic                         apply,
    input  wire bccs_pkg::bccs_flag_mode_t    mode,
    input  wire logic [WIDTH-1:0]             mask,
    output logic [WIDTH-1:0]                  flagsOut
);
    import bccs_pkg::*;

    if (WIDTH < 1) begin : gBadWidth
        $error("Flag width must be at least one bit");
    end

    always_comb begin
        flagsOut = flagsIn;
        if (apply) begin
            case (mode)
                FLAG_SET:    flagsOut = flagsIn | mask;
                FLAG_CLEAR:  flagsOut = flagsIn & ~mask;
                FLAG_TOGGLE: flagsOut = flagsIn ^ mask;
                FLAG_LOAD:   flagsOut = mask;
                default:     flagsOut = flagsIn;
            endcase
        end
    end

endmodule : bccs_flag_unit

//--- bccs_pkg.sv
// Constants, types and register map of the controller condition status block
package bccs_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int FLAG_W = 8;
    localparam int RESULT_W = 7;
    localparam int IRQ_W = 2;

    localparam logic [ADDR_W-1:0] ADDR_MASTER_CFG  = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_COND_STATUS = 16'h0037;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS  = 16'h0040;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK    = 16'h0041;

    localparam int CFG_LAUNCH_POS = 13;
    localparam int CFG_ENABLE_POS = 12;
    localparam int RUN_POS        = 15;
    localparam int RESULT_LSB     = 8;
    localparam int FLAG_MODE_LSB  = 8;
    localparam int IRQ_TRAP_POS   = 0;
    localparam int IRQ_HALT_POS   = 1;

    localparam logic              CFG_ENABLE_RESET = 1'h0;
    localparam logic [FLAG_W-1:0] FLAGS_RESET      = 8'h00;
    localparam logic [RESULT_W-1:0] RESULT_RESET   = 7'h00;
    localparam logic [IRQ_W-1:0]  IRQ_RESET        = 2'h0;
    localparam logic [DATA_W-1:0] READ_IDLE        = 16'h0000;

    typedef enum logic [1:0] {
        FLAG_SET,
        FLAG_CLEAR,
        FLAG_TOGGLE,
        FLAG_LOAD
    } bccs_flag_mode_t;

    typedef enum logic {
        RUN_STOPPED,
        RUN_ACTIVE
    } bccs_run_t;

endpackage : bccs_pkg

//--- bccs_seq_model.sv
// Sequencer stand-in that pulses the op and result inputs of the condition status block
`timescale 1ns/1ps
module bccs_seq_model (
    input  wire logic                         sys_clk,
    output logic                              haltOp,
    output logic                              illegalOpcode,
    output logic                              flagManipulateOp,
    output bccs_pkg::bccs_flag_mode_t         flagOpMode,
    output logic [7:0]                        flagOpMask,
    output logic                              frameTimerCompareOp,
    output logic                              messageTimerCompareOp,
    output logic                              compareLess,
    output logic                              compareEqual,
    output logic                              messageDone,
    output logic [6:0]                        messageResult
);
    import bccs_pkg::*;

    initial begin
        {haltOp, illegalOpcode, flagManipulateOp, frameTimerCompareOp} = 4'h0;
        {messageTimerCompareOp, messageDone, compareLess, compareEqual} = 4'h0;
        flagOpMode = FLAG_SET;
        flagOpMask = 8'h00;
        messageResult = 7'h00;
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-cycle op: 0 halt, 1 illegal, 2 flag, 3 frame cmp, 4 msg cmp, 5 done
    task automatic fire(input logic [2:0] sel, input bccs_flag_mode_t mode, input logic [7:0] val);
        @(posedge sys_clk);
        haltOp <= (sel == 3'h0);
        illegalOpcode <= (sel == 3'h1);
        flagManipulateOp <= (sel == 3'h2);
        frameTimerCompareOp <= (sel == 3'h3);
        messageTimerCompareOp <= (sel == 3'h4);
        messageDone <= (sel == 3'h5);
        flagOpMode <= mode;
        flagOpMask <= val;
        {compareLess, compareEqual} <= val[1:0];
        messageResult <= val[6:0];
        @(posedge sys_clk);
        {haltOp, illegalOpcode, flagManipulateOp} <= 3'h0;
        {frameTimerCompareOp, messageTimerCompareOp, messageDone} <= 3'h0;
        // Stale operands inverted so nothing leans on a held value
        flagOpMask <= ~val;
        {compareLess, compareEqual} <= ~val[1:0];
        messageResult <= ~val[6:0];
    endtask : fire
endmodule : bccs_seq_model
